// ### logic/itb_pkg.sv
// Constants and types shared by the interval and time-base timer
package itb_pkg;

    // Register addresses
    localparam logic [15:0] ADDR_OUT_SEL     = 16'hff92;
    localparam logic [15:0] ADDR_MODE        = 16'hffb0;
    localparam logic [15:0] ADDR_COUNT       = 16'hffb1;
    localparam logic [15:0] ADDR_CLK_STOP    = 16'hfffa;
    localparam logic [15:0] ADDR_IRQ_STATUS  = 16'hffc0;
    localparam logic [15:0] ADDR_IRQ_ENABLE  = 16'hffc1;
    localparam logic [15:0] ADDR_PORT_MODE   = 16'hffc2;

    // Reset values
    localparam logic [7:0]  MODE_RST         = 8'h10;
    localparam logic [7:0]  COUNT_RST        = 8'h00;
    localparam logic [7:0]  CLK_STOP_RST     = 8'hff;
    localparam logic [7:0]  OUT_SEL_RST      = 8'hfe;
    localparam logic [7:0]  ZERO_BYTE        = 8'h00;
    localparam logic [7:0]  COUNT_FULL       = 8'hff;

    // Fields
    localparam logic [7:0]  MODE_RSVD_MASK   = 8'h10;
    localparam logic [7:0]  OUT_SEL_RSVD     = 8'hfe;
    localparam int          MODE_OSEL_LSB    = 5;
    localparam int          MODE_TB_BIT      = 3;
    localparam int          MODE_CLR_BIT     = 2;
    localparam int          STANDBY_BIT      = 0;
    localparam int          SUB_DIRECT_BIT   = 0;
    localparam int          PORT_OUT_EN_BIT  = 0;
    localparam int          OVF_BIT          = 0;

    // Prescaler widths
    localparam int          SYS_PS_W         = 13;
    localparam int          SUB_PS_W         = 7;
    localparam int          TAP_W            = 4;

    // Interval taps as log2 of the system divisor: /8192 down to /8
    localparam logic [TAP_W-1:0] SYS_TAP [8] = '{4'hd, 4'hc, 4'hb, 4'h9, 4'h8, 4'h7, 4'h5, 4'h3};
    // Time-base taps: 256 counts times /128, /64, /32, /4 gives /32768, /16384, /8192, /1024
    localparam logic [TAP_W-1:0] SUB_TAP [4] = '{4'h7, 4'h6, 4'h5, 4'h2};
    // Output waveform bit for /32 down to /4
    localparam logic [2:0]  OUT_DIV32_BIT    = 3'h4;

    // Operating mode of the chip
    typedef enum logic [1:0] {
        PWR_ACTIVE    = 2'b00,
        PWR_SLEEP     = 2'b01,
        PWR_SUBACTIVE = 2'b10,
        PWR_WATCH     = 2'b11
    } pwr_mode_t;

endpackage : itb_pkg

// ### logic/prescaler_stage.sv
// Free-running binary prescaler with synchronous clear
`timescale 1ns/10ps
module prescaler_stage #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             clr,
    input  wire logic             adv,
    // Count
    output logic      [WIDTH-1:0] count
);

    logic [WIDTH-1:0] count_nxt;

    assign count_nxt = clr ? '0 : (adv ? count + 1'b1 : count);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            count <= '0;
        else
            count <= count_nxt;
    end

endmodule : prescaler_stage

// ### logic/tap_tick.sv
// One-cycle tick when a prescaler passes a power-of-two boundary
`timescale 1ns/10ps
module tap_tick #(
    parameter int WIDTH = 8,
    parameter int TW    = 4
) (
    // Prescaler state
    input  wire logic [WIDTH-1:0] count,
    input  wire logic             adv,
    input  wire logic [TW-1:0]    tap,
    // Tick
    output logic                  tick
);

    logic [WIDTH-1:0] low_mask;

    // Tap of zero would tick on every advance
    assign low_mask = ~({WIDTH{1'b1}} << tap);
    assign tick     = adv & (&(count | ~low_mask));

endmodule : tap_tick

// ### logic/interval_timebase_timer.sv
// Eight-bit interval and time-base timer with divided clock output
//
// Functional notes
// - Interval mode counts on one of eight system prescaler taps from /8 to /8192.
// - Time-base mode gives overflow periods of subclock /32768, /16384, /8192 or /1024.
// - Every counter overflow sets the overflow request flag.
// - With direct subclock off, the three output select bits pick system or subclock /32, /16, /8 or /4.
// - With direct subclock on, the pin carries the undivided subclock whatever the select bits say.
// - System divided outputs exist only in active and sleep, subclock divided ones also in subactive.
// - Mode bit 4 always reads one and ignores writes.
// - Reset loads the mode register with 10 hex.
// - A standby control bit parks the timer independently of the rest of the chip.
// - One output-only pin carries the selected waveform.
// - Low four mode bits pick the counter input, and 11 in the top two hold counter and subclock prescaler clear.
// - From FF the next input clock overflows to zero and counting goes on, one overflow per 256 inputs.
// - The pin carries the clock only while the port mode enable bit is one.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module interval_timebase_timer (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [15:0]       addr,
    input  wire logic [7:0]        wr_data,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [7:0]        rd_data,
    // Chip state
    input  wire itb_pkg::pwr_mode_t pwr_mode,
    input  wire logic              sub_clk_in,
    // Pin and interrupt
    output logic                   divided_clock_out_pin,
    output logic                   irq
);

    // Register state
    logic [7:0]                    mode_r;
    logic [7:0]                    mode_nxt;
    logic [7:0]                    count_r;
    logic [7:0]                    count_nxt;
    logic [7:0]                    clk_stop_r;
    logic [7:0]                    clk_stop_nxt;
    logic                          sub_direct_r;
    logic                          sub_direct_nxt;
    logic                          port_en_r;
    logic                          port_en_nxt;
    logic                          ovf_flag_r;
    logic                          ovf_flag_nxt;
    logic                          ovf_en_r;
    logic                          ovf_en_nxt;
    logic [7:0]                    rd_data_r;
    logic [7:0]                    rd_data_nxt;
    logic                          sub_q_r;
    logic                          pin_r;
    logic                          pin_nxt;

    // Decode
    wire                           wr_mode;
    wire                           wr_clk_stop;
    wire                           wr_out_sel;
    wire                           wr_port;
    wire                           wr_irq_stat;
    wire                           wr_irq_en;
    wire                           hit_mode;
    wire                           hit_count;
    wire                           hit_clk_stop;
    wire                           hit_out_sel;
    wire                           hit_port;
    wire                           hit_irq_stat;
    wire                           hit_irq_en;

    // Timing
    wire                           sys_run;
    wire                           sub_div_ok;
    wire                           standby;
    wire                           time_base;
    wire                           clear_hold;
    wire                           sub_edge;
    wire [itb_pkg::SYS_PS_W-1:0]   sys_ps;
    wire [itb_pkg::SUB_PS_W-1:0]   sub_ps;
    wire                           sys_tick;
    wire                           sub_tick;
    wire                           cnt_tick;
    wire                           overflow;
    wire [itb_pkg::TAP_W-1:0]      sys_tap;
    wire [itb_pkg::TAP_W-1:0]      sub_tap;
    wire [2:0]                     out_sel;
    wire [2:0]                     out_bit;
    wire                           sys_wave;
    wire                           sub_wave;
    wire                           sel_wave;
    wire                           sel_ok;
    wire [7:0]                     count_view;

    // Read views
    wire [7:0]                     mode_view;
    wire [7:0]                     out_sel_view;
    wire [7:0]                     port_view;
    wire [7:0]                     stat_view;
    wire [7:0]                     en_view;

    assign hit_mode     = (addr == itb_pkg::ADDR_MODE);
    assign hit_count    = (addr == itb_pkg::ADDR_COUNT);
    assign hit_clk_stop = (addr == itb_pkg::ADDR_CLK_STOP);
    assign hit_out_sel  = (addr == itb_pkg::ADDR_OUT_SEL);
    assign hit_port     = (addr == itb_pkg::ADDR_PORT_MODE);
    assign hit_irq_stat = (addr == itb_pkg::ADDR_IRQ_STATUS);
    assign hit_irq_en   = (addr == itb_pkg::ADDR_IRQ_ENABLE);

    assign wr_mode      = wr_stb & hit_mode;
    assign wr_clk_stop  = wr_stb & hit_clk_stop;
    assign wr_out_sel   = wr_stb & hit_out_sel;
    assign wr_port      = wr_stb & hit_port;
    assign wr_irq_stat  = wr_stb & hit_irq_stat;
    assign wr_irq_en    = wr_stb & hit_irq_en;

    // System clock stops outside active and sleep, so its prescaler stalls there
    assign sys_run    = (pwr_mode == itb_pkg::PWR_ACTIVE) || (pwr_mode == itb_pkg::PWR_SLEEP);
    assign sub_div_ok = sys_run || (pwr_mode == itb_pkg::PWR_SUBACTIVE);
    assign standby    = ~clk_stop_r[itb_pkg::STANDBY_BIT];
    assign time_base  = mode_r[itb_pkg::MODE_TB_BIT];
    assign clear_hold = time_base & mode_r[itb_pkg::MODE_CLR_BIT];

    // Subclock arrives synchronous; one stage finds its rising edge
    assign sub_edge = sub_clk_in & ~sub_q_r;

    prescaler_stage #(
        .WIDTH (itb_pkg::SYS_PS_W)
    ) u_system_prescaler (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clr     (1'b0),
        .adv     (sys_run),
        .count   (sys_ps)
    );

    prescaler_stage #(
        .WIDTH (itb_pkg::SUB_PS_W)
    ) u_subclock_prescaler (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clr     (clear_hold),
        .adv     (sub_edge),
        .count   (sub_ps)
    );

    assign sys_tap = itb_pkg::SYS_TAP[mode_r[2:0]];
    assign sub_tap = itb_pkg::SUB_TAP[mode_r[1:0]];

    tap_tick #(
        .WIDTH (itb_pkg::SYS_PS_W),
        .TW    (itb_pkg::TAP_W)
    ) u_system_tap (
        .count (sys_ps),
        .adv   (sys_run),
        .tap   (sys_tap),
        .tick  (sys_tick)
    );

    tap_tick #(
        .WIDTH (itb_pkg::SUB_PS_W),
        .TW    (itb_pkg::TAP_W)
    ) u_subclock_tap (
        .count (sub_ps),
        .adv   (sub_edge),
        .tap   (sub_tap),
        .tick  (sub_tick)
    );

    // Counter input by mode bit 3; standby parks the counter
    assign cnt_tick = ~standby & ~clear_hold & (time_base ? sub_tick : sys_tick);
    assign overflow = cnt_tick & (count_r == itb_pkg::COUNT_FULL);

    always_comb
    begin
        count_nxt = count_r;
        if (clear_hold)
            count_nxt = itb_pkg::COUNT_RST;
        else if (cnt_tick)
            count_nxt = count_r + 8'h01;
    end

    // Mode register; bit 4 is forced, never stored from the bus
    assign mode_nxt = wr_mode ? (wr_data | itb_pkg::MODE_RSVD_MASK) : mode_r;
    assign clk_stop_nxt   = wr_clk_stop ? wr_data : clk_stop_r;
    assign sub_direct_nxt = wr_out_sel ? wr_data[itb_pkg::SUB_DIRECT_BIT] : sub_direct_r;
    assign port_en_nxt    = wr_port ? wr_data[itb_pkg::PORT_OUT_EN_BIT] : port_en_r;
    assign ovf_en_nxt     = wr_irq_en ? wr_data[itb_pkg::OVF_BIT] : ovf_en_r;

    // Set beats a same-cycle write-one clear so no overflow is lost
    assign ovf_flag_nxt = overflow |
                          (ovf_flag_r & ~(wr_irq_stat & wr_data[itb_pkg::OVF_BIT]));

    // Output selection: bit index 4 is /32, down to bit 1 for /4
    assign out_sel  = mode_r[7:itb_pkg::MODE_OSEL_LSB];
    assign out_bit  = itb_pkg::OUT_DIV32_BIT - {1'b0, out_sel[1:0]};
    assign sys_wave = sys_ps[out_bit];
    assign sub_wave = sub_ps[out_bit];
    assign sel_wave = out_sel[2] ? sub_wave : sys_wave;
    assign sel_ok   = ~standby & (out_sel[2] ? sub_div_ok : sys_run);

    always_comb
    begin
        pin_nxt = 1'b0;
        if (port_en_r)
        begin
            if (sub_direct_r)
                pin_nxt = sub_clk_in;
            else if (sel_ok)
                pin_nxt = sel_wave;
        end
    end

    // Count is hidden outside active mode
    assign count_view = (pwr_mode == itb_pkg::PWR_ACTIVE) ? count_r : itb_pkg::ZERO_BYTE;

    // Unused bits read as the reserved pattern or zero
    assign mode_view    = mode_r | itb_pkg::MODE_RSVD_MASK;
    assign out_sel_view = itb_pkg::OUT_SEL_RSVD | {7'h00, sub_direct_r};
    assign port_view    = {7'h00, port_en_r};
    assign stat_view    = {7'h00, ovf_flag_r};
    assign en_view      = {7'h00, ovf_en_r};

    always_comb
    begin
        rd_data_nxt = itb_pkg::ZERO_BYTE;
        if (rd_stb)
        begin
            if (hit_mode)
                rd_data_nxt = mode_view;
            else if (hit_count)
                rd_data_nxt = count_view;
            else if (hit_clk_stop)
                rd_data_nxt = clk_stop_r;
            else if (hit_out_sel)
                rd_data_nxt = out_sel_view;
            else if (hit_port)
                rd_data_nxt = port_view;
            else if (hit_irq_stat)
                rd_data_nxt = stat_view;
            else if (hit_irq_en)
                rd_data_nxt = en_view;
        end
    end

    // Software-visible control bits
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            mode_r       <= itb_pkg::MODE_RST;
            clk_stop_r   <= itb_pkg::CLK_STOP_RST;
            sub_direct_r <= 1'b0;
            port_en_r    <= 1'b0;
            ovf_en_r     <= 1'b0;
        end
        else
        begin
            mode_r       <= mode_nxt;
            clk_stop_r   <= clk_stop_nxt;
            sub_direct_r <= sub_direct_nxt;
            port_en_r    <= port_en_nxt;
            ovf_en_r     <= ovf_en_nxt;
        end
    end

    // Counter and its sticky overflow flag
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            count_r      <= itb_pkg::COUNT_RST;
            ovf_flag_r   <= 1'b0;
        end
        else
        begin
            count_r      <= count_nxt;
            ovf_flag_r   <= ovf_flag_nxt;
        end
    end

    // Registered outputs keep read data and pin free of decode glitches
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rd_data_r    <= itb_pkg::ZERO_BYTE;
            pin_r        <= 1'b0;
        end
        else
        begin
            rd_data_r    <= rd_data_nxt;
            pin_r        <= pin_nxt;
        end
    end

    // Subclock sample runs through reset so no false edge follows release
    always_ff @(posedge sys_clk)
    begin
        sub_q_r <= sub_clk_in;
    end

    assign rd_data               = rd_data_r;
    assign divided_clock_out_pin = pin_r;
    assign irq                   = ovf_flag_r & ovf_en_r;

endmodule : interval_timebase_timer

// ### verification/itb_props.sv
// Concurrent checks on the timer register port, pin and interrupt
`timescale 1ns/10ps
module itb_props (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               rst_n,
    // Register port
    input wire logic [15:0]        addr,
    input wire logic [7:0]         wr_data,
    input wire logic               wr_stb,
    input wire logic               rd_stb,
    input wire logic [7:0]         rd_data,
    // Chip state and outputs
    input wire itb_pkg::pwr_mode_t pwr_mode,
    input wire logic               sub_clk_in,
    input wire logic               divided_clock_out_pin,
    input wire logic               irq
);
    // Shadows of control bits, kept from the write strobes
    logic       pen_r;
    logic       dir_r;
    logic       ien_r;
    logic       run_r;
    logic [2:0] sel_r;
    wire        wr_irq = wr_stb && addr[15:1] == itb_pkg::ADDR_IRQ_STATUS[15:1];
    wire        sys_out = pen_r && !dir_r && run_r && !sel_r[2];
    wire        no_sys = pwr_mode == itb_pkg::PWR_SUBACTIVE || pwr_mode == itb_pkg::PWR_WATCH;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pen_r <= 1'b0;
            dir_r <= 1'b0;
            ien_r <= 1'b0;
            run_r <= 1'b1;
            sel_r <= 3'h0;
        end
        else if (wr_stb)
        begin
            if (addr == itb_pkg::ADDR_PORT_MODE) pen_r <= wr_data[0];
            if (addr == itb_pkg::ADDR_OUT_SEL) dir_r <= wr_data[0];
            if (addr == itb_pkg::ADDR_IRQ_ENABLE) ien_r <= wr_data[0];
            if (addr == itb_pkg::ADDR_CLK_STOP) run_r <= wr_data[0];
            if (addr == itb_pkg::ADDR_MODE) sel_r <= wr_data[7:5];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_mode_rsvd_one: assert property (rd_stb && addr == itb_pkg::ADDR_MODE |=> rd_data[4])
        else $error("mode bit 4 read back as zero");
    chk_outsel_rsvd: assert property (rd_stb && addr == itb_pkg::ADDR_OUT_SEL |=> rd_data[7:1] == 7'h7f)
        else $error("output select upper bits not all ones");
    chk_count_hidden: assert property (rd_stb && addr == itb_pkg::ADDR_COUNT
        && pwr_mode != itb_pkg::PWR_ACTIVE |=> rd_data == 8'h00)
        else $error("count visible outside active mode");
    chk_rd_idle: assert property (!rd_stb |=> rd_data == 8'h00)
        else $error("read data present without a read");
    chk_pin_gated: assert property (!pen_r |=> !divided_clock_out_pin)
        else $error("pin driven with port enable off");
    chk_direct_sub: assert property (pen_r && dir_r |=> divided_clock_out_pin == $past(sub_clk_in))
        else $error("pin does not follow the subclock");
    chk_sys_div4: assert property ((sys_out && sel_r == 3'h3 && pwr_mode == itb_pkg::PWR_ACTIVE)[*3]
        |=> divided_clock_out_pin != $past(divided_clock_out_pin, 2))
        else $error("system quarter clock not toggling every two cycles");
    chk_sys_off: assert property (sys_out && no_sys |=> !divided_clock_out_pin)
        else $error("system clock output outside active and sleep");
    chk_irq_masked: assert property (!ien_r |-> !irq)
        else $error("interrupt while disabled");
    chk_irq_sticky: assert property (irq && ien_r && !wr_irq |=> irq)
        else $error("interrupt dropped without a clear");
endmodule : itb_props

// ### verification/interval_timebase_timer_test.sv
// Self-checking bench for the interval and time-base timer
`timescale 1ns/10ps
module interval_timebase_timer_test;
    logic               sys_clk;
    logic               rst_n;
    logic [15:0]        addr;
    logic [7:0]         wr_data;
    logic               wr_stb;
    logic               rd_stb;
    logic [7:0]         rd_data;
    itb_pkg::pwr_mode_t pwr_mode;
    logic [1:0]         sub_cnt = 2'h0;
    logic               divided_clock_out_pin;
    logic               irq;
    logic               rd_seen = 1'b0;
    logic [23:0]        exp_q[$];
    logic [7:0]         rnd;
    logic               pin_q;
    int                 num_errors = 0;
    int                 total_checks = 0;
    int                 cyc = 0;
    int                 t1;
    interval_timebase_timer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .pwr_mode(pwr_mode), .sub_clk_in(sub_cnt[1]),
        .divided_clock_out_pin(divided_clock_out_pin), .irq(irq));
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Subclock at a quarter of the system rate, free running like the oscillator
    always @(posedge sys_clk)
    begin
        sub_cnt <= sub_cnt + 2'h1;
        cyc <= cyc + 1;
        rd_seen <= rd_stb & rst_n;
        if (rd_seen)
        begin
            check($sformatf("reg %h", exp_q[0][23:8]), rd_data, exp_q[0][7:0]);
            void'(exp_q.pop_front());
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // A gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    task automatic wait_irq(input int lim);
        int t;
        t = 0;
        while (irq !== 1'b1 && t < lim)
        begin
            @(posedge sys_clk);
            t++;
        end
        check("irq wait", t < lim, 1);
    endtask : wait_irq
    // Counter start value is unknown, so only the gap between overflows is exact
    task automatic measure(input logic [7:0] m, input int per);
        wr(itb_pkg::ADDR_MODE, m);
        wr(itb_pkg::ADDR_IRQ_STATUS, 8'h01);
        wait_irq(2 * per + 64);
        t1 = cyc;
        wr(itb_pkg::ADDR_IRQ_STATUS, 8'h01);
        wait_irq(per + 64);
        check("overflow period", cyc - t1, per);
    endtask : measure
    task automatic results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        results();
    end
    initial
    begin
        {addr, wr_data, wr_stb, rd_stb, rst_n} = '0;
        pwr_mode = itb_pkg::PWR_ACTIVE;
        void'($urandom(22706));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(itb_pkg::ADDR_MODE, 8'h10);
        rd(itb_pkg::ADDR_COUNT, 8'h00);
        rd(itb_pkg::ADDR_CLK_STOP, 8'hff);
        rd(itb_pkg::ADDR_OUT_SEL, 8'hfe);
        rd(itb_pkg::ADDR_IRQ_STATUS, 8'h00);
        rd(16'hff00 | 16'($urandom % 16), 8'h00);
        rnd = 8'($urandom);
        wr(itb_pkg::ADDR_MODE, (rnd & 8'he3) | 8'h0c);
        rd(itb_pkg::ADDR_MODE, (rnd & 8'he3) | 8'h1c);
        wr(itb_pkg::ADDR_COUNT, rnd);
        rd(itb_pkg::ADDR_COUNT, 8'h00);
        wr(itb_pkg::ADDR_IRQ_ENABLE, 8'h01);
        measure(8'h07, 2048);
        measure(8'h06, 8192);
        measure(8'h0b, 4096);
        wr(itb_pkg::ADDR_IRQ_ENABLE, 8'h00);
        check("irq masked", irq, 1'b0);
        rd(itb_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr(itb_pkg::ADDR_IRQ_STATUS, 8'h01);
        rd(itb_pkg::ADDR_IRQ_STATUS, 8'h00);
        wr(itb_pkg::ADDR_PORT_MODE, 8'h01);
        wr(itb_pkg::ADDR_MODE, 8'h60);
        repeat (20) @(posedge sys_clk);
        pwr_mode <= itb_pkg::PWR_SUBACTIVE;
        rd(itb_pkg::ADDR_COUNT, 8'h00);
        pwr_mode <= itb_pkg::PWR_WATCH;
        repeat (8) @(posedge sys_clk);
        pwr_mode <= itb_pkg::PWR_SUBACTIVE;
        wr(itb_pkg::ADDR_MODE, 8'h80);
        repeat (8) @(posedge sys_clk);
        t1 = 0;
        pin_q = divided_clock_out_pin;
        repeat (256)
        begin
            @(posedge sys_clk);
            t1 += divided_clock_out_pin & ~pin_q;
            pin_q = divided_clock_out_pin;
        end
        check("subclock div32 rises", t1, 2);
        pwr_mode <= itb_pkg::PWR_ACTIVE;
        wr(itb_pkg::ADDR_OUT_SEL, 8'($urandom) | 8'h01);
        rd(itb_pkg::ADDR_OUT_SEL, 8'hff);
        repeat (20) @(posedge sys_clk);
        wr(itb_pkg::ADDR_PORT_MODE, 8'h00);
        repeat (4) @(posedge sys_clk);
        check("pin off", divided_clock_out_pin, 1'b0);
        wr(itb_pkg::ADDR_CLK_STOP, 8'hfe);
        rd(itb_pkg::ADDR_CLK_STOP, 8'hfe);
        wr(itb_pkg::ADDR_OUT_SEL, 8'h00);
        wr(itb_pkg::ADDR_PORT_MODE, 8'h01);
        t1 = 0;
        repeat (128)
        begin
            @(posedge sys_clk);
            t1 += divided_clock_out_pin;
        end
        check("pin in standby", t1, 0);
        repeat (4) @(posedge sys_clk);
        results();
    end
endmodule : interval_timebase_timer_test
bind interval_timebase_timer itb_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .pwr_mode(pwr_mode), .sub_clk_in(sub_clk_in),
    .divided_clock_out_pin(divided_clock_out_pin), .irq(irq));
